// ### logic/tlmm_pkg.sv
// Constants, register map and factory table contents for the resistor table memory map
package tlmm_pkg;

  // ****************************************************************
  // Register map and decode values
  // ****************************************************************
  localparam logic [7:0] ADDR_TABLE_SELECT = 8'he0;
  localparam logic [7:0] ADDR_UPDATE_CONFIG = 8'he1;
  localparam logic [7:0] SEL_USER = 8'h00;
  localparam logic [7:0] SEL_LUT1 = 8'h01;
  localparam logic [7:0] SEL_LUT2 = 8'h02;
  localparam logic [7:0] TABLE_SELECT_RESET = 8'h00;
  localparam logic [7:0] UPDATE_CONFIG_RESET = 8'h03;
  localparam int CFG_INDEX_EN_BIT = 0;
  localparam int CFG_TEMP_EN_BIT = 1;
  localparam int CFG_FLAG_BIT = 2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // Store sizes and temperature steps
  // ****************************************************************
  localparam int USER_DEPTH = 128;
  localparam int LUT_DEPTH = 72;
  localparam logic [6:0] LUT_LAST = 7'h47;
  localparam logic [8:0] TEMP_OFFSET = 9'h028;
  localparam logic [1:0] KIND_USER = 2'h0;
  localparam logic [1:0] KIND_LUT1 = 2'h1;
  localparam logic [1:0] KIND_LUT2 = 2'h2;

  // ****************************************************************
  // Factory contents
  // ****************************************************************
  localparam logic [6:0] USER_COPY1_LO = 7'h60;
  localparam logic [6:0] USER_COPY2_LO = 7'h6c;
  localparam logic [6:0] COPY_LEN = 7'h0c;
  localparam logic [6:0] LUT_COPY_LO = 7'h28;

  // Shipping pattern of the tables; the ramp shape itself is arbitrary
  function automatic logic [7:0] lut_default(input logic [1:0] kind, input logic [6:0] idx);
    logic [7:0] v;
    v = (kind == KIND_LUT1) ? {idx, 1'b0} : (8'hff - {1'b0, idx});
    return v;
  endfunction : lut_default

  function automatic logic [7:0] init_value(input logic [1:0] kind, input logic [6:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (kind != KIND_USER)
      v = lut_default(kind, idx);
    else if (idx >= USER_COPY1_LO && idx < USER_COPY1_LO + COPY_LEN)
      v = lut_default(KIND_LUT1, idx - USER_COPY1_LO + LUT_COPY_LO);
    else if (idx >= USER_COPY2_LO && idx < USER_COPY2_LO + COPY_LEN)
      v = lut_default(KIND_LUT2, idx - USER_COPY2_LO + LUT_COPY_LO);
    return v;
  endfunction : init_value

endpackage : tlmm_pkg

// ### logic/tlmm_mem.sv
// Byte-wide nonvolatile store model with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module tlmm_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter logic [1:0] KIND = 2'h0
) (
  input wire logic sys_clk_i,            // System clock
  input wire logic reset_i,              // Async reset, high
  input wire logic we_i,                 // Write strobe
  input wire logic [AW-1:0] waddr_i,     // Write address
  input wire logic [7:0] wdata_i,        // Write data
  input wire logic [AW-1:0] host_addr_i, // Host read address
  output logic [7:0] host_data_o,        // Host read data, registered
  input wire logic [AW-1:0] idx_addr_i,  // Resistor read address
  output logic [7:0] idx_data_o          // Resistor read data, registered
);

  logic [7:0] mem [DEPTH];

  // Reset stands in for the factory-programmed contents
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= tlmm_pkg::init_value(KIND, 7'(i));
      host_data_o <= 8'h00;
      idx_data_o <= 8'h00;
    end
    else
    begin
      if (we_i && 32'(waddr_i) < DEPTH)
        mem[waddr_i] <= wdata_i;
      host_data_o <= (32'(host_addr_i) < DEPTH) ? mem[host_addr_i] : 8'h00;
      idx_data_o <= (32'(idx_addr_i) < DEPTH) ? mem[idx_addr_i] : 8'h00;
    end
  end

endmodule : tlmm_mem

`default_nettype wire

// ### logic/tlmm_top.sv
// Memory map, table select, update configuration and resistor table lookup
// Functional notes
// - table entry zero is minus forty degrees, each next entry two degrees warmer
// - select 00h maps user store, 01h first table, 02h second table
// - each table holds 72 bytes, separate from user store
// - shipped user 60h-6Bh copy first table entries 28h-33h
// - shipped user 6Ch-77h copy second table entries 28h-33h
// - configuration byte at E1h resets to 03h
// - configuration holds temperature update enable and index update enable
// - completion flag sets when conversion refreshed temperature and index
// - host may clear the flag; it stays zero until next completion
// - every table entry accepts any code 00h to FFh
`timescale 1ns/1ps
`default_nettype none

module tlmm_top (
  input wire logic sys_clk_i,           // 125 MHz system clock
  input wire logic reset_i,             // Async reset, high
  input wire logic [7:0] addr_i,        // Register/memory byte address
  input wire logic wr_i,                // Write strobe, one cycle
  input wire logic [7:0] wdata_i,       // Write data
  input wire logic rd_i,                // Read strobe, one cycle
  output logic [7:0] rdata_o,           // Read data
  output logic rvalid_o,                // Read data valid, one cycle
  input wire logic signed [7:0] temp_i, // Converted temperature, whole degrees
  input wire logic conv_done_i,         // Conversion finished, one cycle
  output logic [7:0] temp_o,            // Held temperature result
  output logic [6:0] lut_index_o,       // Current table index
  output logic [7:0] res0_o,            // First resistor code
  output logic [7:0] res1_o,            // Second resistor code
  output logic update_complete_flag_o   // Completion flag
);

  typedef enum logic [2:0] {SRC_NONE, SRC_USER, SRC_LUT1, SRC_LUT2, SRC_REG} tlmm_src_t;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [7:0] table_select;
  logic low_win;
  logic user_hit;
  logic lut1_hit;
  logic lut2_hit;

  always_comb
  begin
    low_win = ~addr_i[7];
    user_hit = low_win && table_select == tlmm_pkg::SEL_USER;
    lut1_hit = low_win && table_select == tlmm_pkg::SEL_LUT1
      && addr_i[6:0] <= tlmm_pkg::LUT_LAST;
    lut2_hit = low_win && table_select == tlmm_pkg::SEL_LUT2
      && addr_i[6:0] <= tlmm_pkg::LUT_LAST;
  end

  // ****************************************************************
  // Configuration and temperature state
  // ****************************************************************
  logic index_update_enable;
  logic temp_update_enable;
  logic next_index_update_enable;
  logic next_temp_update_enable;
  logic next_update_complete_flag;
  logic [7:0] next_table_select;
  logic [7:0] next_temp;
  logic [6:0] next_lut_index;
  logic signed [7:0] temp_src;
  logic [8:0] idx_sum;
  logic refresh;
  logic [7:0] cfg_byte;

  always_comb
  begin
    cfg_byte = 8'h00;
    cfg_byte[tlmm_pkg::CFG_INDEX_EN_BIT] = index_update_enable;
    cfg_byte[tlmm_pkg::CFG_TEMP_EN_BIT] = temp_update_enable;
    cfg_byte[tlmm_pkg::CFG_FLAG_BIT] = update_complete_flag_o;
    next_table_select = table_select;
    next_index_update_enable = index_update_enable;
    next_temp_update_enable = temp_update_enable;
    next_update_complete_flag = update_complete_flag_o;
    if (wr_i && addr_i == tlmm_pkg::ADDR_TABLE_SELECT)
      next_table_select = wdata_i;
    if (wr_i && addr_i == tlmm_pkg::ADDR_UPDATE_CONFIG)
    begin
      next_index_update_enable = wdata_i[tlmm_pkg::CFG_INDEX_EN_BIT];
      next_temp_update_enable = wdata_i[tlmm_pkg::CFG_TEMP_EN_BIT];
      // Writing one leaves the flag alone; only hardware sets it
      if (!wdata_i[tlmm_pkg::CFG_FLAG_BIT])
        next_update_complete_flag = 1'b0;
    end
    // Index follows the fresh sample when it was taken, else the held one
    temp_src = temp_update_enable ? temp_i : $signed(temp_o);
    next_temp = (conv_done_i && temp_update_enable) ? temp_i : temp_o;
    idx_sum = {temp_src[7], temp_src} + tlmm_pkg::TEMP_OFFSET;
    next_lut_index = lut_index_o;
    if (conv_done_i && index_update_enable)
    begin
      if (idx_sum[8])
        next_lut_index = 7'h00;
      else if (idx_sum[7:1] > tlmm_pkg::LUT_LAST)
        next_lut_index = tlmm_pkg::LUT_LAST;
      else
        next_lut_index = idx_sum[7:1];
    end
    // Completion needs both refreshes; a set in the clear cycle wins
    refresh = conv_done_i && temp_update_enable && index_update_enable;
    if (refresh)
      next_update_complete_flag = 1'b1;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      table_select <= tlmm_pkg::TABLE_SELECT_RESET;
      index_update_enable <= tlmm_pkg::UPDATE_CONFIG_RESET[tlmm_pkg::CFG_INDEX_EN_BIT];
      temp_update_enable <= tlmm_pkg::UPDATE_CONFIG_RESET[tlmm_pkg::CFG_TEMP_EN_BIT];
      update_complete_flag_o <= tlmm_pkg::UPDATE_CONFIG_RESET[tlmm_pkg::CFG_FLAG_BIT];
      temp_o <= 8'h00;
      lut_index_o <= 7'h00;
    end
    else
    begin
      table_select <= next_table_select;
      index_update_enable <= next_index_update_enable;
      temp_update_enable <= next_temp_update_enable;
      update_complete_flag_o <= next_update_complete_flag;
      temp_o <= next_temp;
      lut_index_o <= next_lut_index;
    end
  end

  // ****************************************************************
  // Stores
  // ****************************************************************
  logic [7:0] user_q;
  logic [7:0] lut1_q;
  logic [7:0] lut2_q;

  // Shipped user contents carry the table copies
  tlmm_mem #(.DEPTH(tlmm_pkg::USER_DEPTH), .AW(7), .KIND(tlmm_pkg::KIND_USER)) u_user (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .we_i(wr_i && user_hit),
    .waddr_i(addr_i[6:0]),
    .wdata_i(wdata_i),
    .host_addr_i(addr_i[6:0]),
    .host_data_o(user_q),
    .idx_addr_i(7'h00),
    .idx_data_o()
  );

  // Resistor codes come straight from the table read registers
  tlmm_mem #(.DEPTH(tlmm_pkg::LUT_DEPTH), .AW(7), .KIND(tlmm_pkg::KIND_LUT1)) u_lut1 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .we_i(wr_i && lut1_hit),
    .waddr_i(addr_i[6:0]),
    .wdata_i(wdata_i),
    .host_addr_i(addr_i[6:0]),
    .host_data_o(lut1_q),
    .idx_addr_i(lut_index_o),
    .idx_data_o(res0_o)
  );

  tlmm_mem #(.DEPTH(tlmm_pkg::LUT_DEPTH), .AW(7), .KIND(tlmm_pkg::KIND_LUT2)) u_lut2 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .we_i(wr_i && lut2_hit),
    .waddr_i(addr_i[6:0]),
    .wdata_i(wdata_i),
    .host_addr_i(addr_i[6:0]),
    .host_data_o(lut2_q),
    .idx_addr_i(lut_index_o),
    .idx_data_o(res1_o)
  );

  // ****************************************************************
  // Read pipeline
  // ****************************************************************
  tlmm_src_t src_q;
  tlmm_src_t next_src;
  logic [7:0] reg_q;
  logic [7:0] next_reg;
  logic [7:0] next_rdata;

  always_comb
  begin
    next_src = SRC_NONE;
    next_reg = tlmm_pkg::UNMAPPED_READ;
    if (rd_i)
    begin
      // Anything not decoded reads as zero but still answers
      next_src = SRC_REG;
      if (user_hit)
        next_src = SRC_USER;
      else if (lut1_hit)
        next_src = SRC_LUT1;
      else if (lut2_hit)
        next_src = SRC_LUT2;
      else if (addr_i == tlmm_pkg::ADDR_TABLE_SELECT)
        next_reg = table_select;
      else if (addr_i == tlmm_pkg::ADDR_UPDATE_CONFIG)
        next_reg = cfg_byte;
    end
    unique case (src_q)
      SRC_USER: next_rdata = user_q;
      SRC_LUT1: next_rdata = lut1_q;
      SRC_LUT2: next_rdata = lut2_q;
      SRC_REG: next_rdata = reg_q;
      SRC_NONE: next_rdata = rdata_o;
      default: next_rdata = tlmm_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      src_q <= SRC_NONE;
      reg_q <= 8'h00;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      src_q <= next_src;
      reg_q <= next_reg;
      rdata_o <= next_rdata;
      rvalid_o <= src_q != SRC_NONE;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_cfg_read;
    rd_i && !wr_i && addr_i == tlmm_pkg::ADDR_UPDATE_CONFIG;
  endsequence

  sequence s_cfg_answer;
    ##2 rvalid_o && rdata_o[7:3] == 5'h00;
  endsequence

  sequence s_clear_write;
    wr_i && addr_i == tlmm_pkg::ADDR_UPDATE_CONFIG && !wdata_i[tlmm_pkg::CFG_FLAG_BIT];
  endsequence

  a_cfg_after_reset: assert property (
    $fell(reset_i) |-> index_update_enable && temp_update_enable && !update_complete_flag_o)
    else $error("configuration not 03h after reset");
  a_cfg_read_shape: assert property (s_cfg_read |-> s_cfg_answer)
    else $error("configuration read malformed");
  a_flag_sets: assert property (
    conv_done_i && temp_update_enable && index_update_enable |=> update_complete_flag_o)
    else $error("flag not set on completed update");
  a_set_beats_clear: assert property (
    s_clear_write ##0 refresh |=> update_complete_flag_o)
    else $error("clear beat a same-cycle set");
  a_flag_holds_zero: assert property (
    !update_complete_flag_o && !refresh |=> !update_complete_flag_o)
    else $error("flag rose without a completed update");
  a_select_write: assert property (
    wr_i && addr_i == tlmm_pkg::ADDR_TABLE_SELECT |=> table_select == $past(wdata_i))
    else $error("table select not stored");
  a_read_latency: assert property (rd_i |-> ##2 rvalid_o)
    else $error("read answer not two cycles later");
  a_window_closed: assert property (
    rd_i && !addr_i[7] && table_select > tlmm_pkg::SEL_LUT2 |-> ##2 rdata_o == 8'h00)
    else $error("unmapped window returned data");
  a_index_range: assert property (lut_index_o <= tlmm_pkg::LUT_LAST)
    else $error("table index past last entry");
  a_index_value: assert property (
    conv_done_i && index_update_enable && temp_update_enable
    && temp_i >= 8'shd8 && temp_i <= 8'sh66
    |=> int'(lut_index_o) * 2 - 40 <= int'($past(temp_i))
    && int'($past(temp_i)) <= int'(lut_index_o) * 2 - 39)
    else $error("table index not matching temperature");
  a_temp_held: assert property (conv_done_i && !temp_update_enable |=> $stable(temp_o))
    else $error("temperature updated while disabled");

endmodule : tlmm_top

`default_nettype wire

// ### verif/tlmm_host.sv
// Host model issuing byte reads and writes into the memory map
`timescale 1ns/1ps
`default_nettype none

module tlmm_host (
  input wire logic sys_clk_i,     // System clock
  output logic [7:0] addr_o,      // Byte address
  output logic wr_o,              // Write strobe
  output logic [7:0] wdata_o,     // Write data
  output logic rd_o,              // Read strobe
  input wire logic [7:0] rdata_i, // Read data
  input wire logic rvalid_i       // Read answer valid
);
  initial
  begin
    addr_o = 8'h5a;
    wdata_o = 8'ha5;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    wr_o = 1'b0;
    // Released lines show garbage, so a stale address cannot pass by luck
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge sys_clk_i);
      #1;
      if (rvalid_i === 1'b1)
      begin
        d = rdata_i;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : tlmm_host
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the resistor table memory map
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module tb_top;
  logic sys_clk, reset, wr, rd, rvalid, conv_done, flag;
  logic [7:0] addr, wdata, rdata, temp, temp_o, res0, res1;
  logic [6:0] lut_index;
  logic [31:0] seed = 32'h920c2eb8;
  logic [7:0] lut [2][72];
  logic [7:0] corner [8] = '{8'h80, 8'hd7, 8'hd8, 8'hd9, 8'h66, 8'h67, 8'h7f, 8'h00};
  int n_fail = 0;
  int n_compared = 0;

  tlmm_top dut (.sys_clk_i(sys_clk), .reset_i(reset), .addr_i(addr), .wr_i(wr),
    .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .rvalid_o(rvalid), .temp_i(temp),
    .conv_done_i(conv_done), .temp_o(temp_o), .lut_index_o(lut_index), .res0_o(res0),
    .res1_o(res1), .update_complete_flag_o(flag));

  tlmm_host host (.sys_clk_i(sys_clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction : lfsr

  // Table index from a temperature, clamped to the 72 entries
  function automatic logic [6:0] exp_index(input logic [7:0] t);
    int s;
    s = $signed(t) + 40;
    if (s < 0)
      s = 0;
    s = s / 2;
    if (s > 71)
      s = 71;
    return s[6:0];
  endfunction : exp_index

  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      n_fail++;
      tally_and_finish();
    end
    else
      `CHK(d, e)
  endtask : rd_chk

  task automatic conv_chk(input logic [7:0] t, input logic [7:0] et, input logic [6:0] ei,
    input logic ef);
    @(posedge sys_clk);
    #1;
    temp = t;
    conv_done = 1'b1;
    @(posedge sys_clk);
    #1;
    conv_done = 1'b0;
    seed = lfsr(seed);
    temp = seed[7:0];
    @(posedge sys_clk);
    #1;
    `CHK(temp_o, et)
    `CHK(lut_index, ei)
    `CHK(res0, lut[0][ei])
    `CHK(res1, lut[1][ei])
    `CHK(flag, ef)
  endtask : conv_chk

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    logic [7:0] t, v, idx;
    for (int i = 0; i < 72; i++)
    begin
      lut[0][i] = 8'(2 * i);
      lut[1][i] = 8'hff - 8'(i);
    end
    reset = 1'b1;
    temp = 8'h00;
    conv_done = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(res0, 8'h00)
    `CHK(res1, 8'hff)
    rd_chk(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h03);
    rd_chk(tlmm_pkg::ADDR_TABLE_SELECT, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      rd_chk(8'h60 + 8'(i), lut[0][8'h28 + i]);
      rd_chk(8'h6c + 8'(i), lut[1][8'h28 + i]);
    end
    // Both tables: edge entries, extreme codes, then random places
    for (int s = 0; s < 2; s++)
    begin
      host.wr(tlmm_pkg::ADDR_TABLE_SELECT, 8'(s + 1));
      for (int k = 0; k < 6; k++)
      begin
        seed = lfsr(seed);
        idx = (k == 0) ? 8'h00 : (k == 1) ? 8'h47 : 8'(seed[15:8] % 72);
        v = (k == 2) ? 8'h00 : (k == 3) ? 8'hff : seed[7:0];
        host.wr(idx, v);
        lut[s][idx] = v;
        rd_chk(idx, v);
      end
      host.wr(8'h48, 8'h77);
      rd_chk(8'h48, 8'h00);
    end
    host.wr(tlmm_pkg::ADDR_TABLE_SELECT, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h47, 8'h00);
    host.wr(8'h7f, 8'h3c);
    rd_chk(8'h7f, 8'h3c);
    host.wr(tlmm_pkg::ADDR_TABLE_SELECT, 8'h02);
    rd_chk(8'h47, lut[1][71]);
    host.wr(tlmm_pkg::ADDR_TABLE_SELECT, 8'h03);
    rd_chk(8'h00, 8'h00);
    for (int k = 0; k < 16; k++)
    begin
      seed = lfsr(seed);
      t = (k < 8) ? corner[k] : seed[7:0];
      host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h03);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(flag, 1'b0)
      conv_chk(t, t, exp_index(t), 1'b1);
      rd_chk(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h07);
    end
    // Enables one at a time; the index follows the held temperature
    host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h02);
    conv_chk(8'h10, 8'h10, exp_index(t), 1'b0);
    host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h01);
    conv_chk(8'hf0, 8'h10, exp_index(8'h10), 1'b0);
    host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h00);
    conv_chk(8'h50, 8'h10, exp_index(8'h10), 1'b0);
    rd_chk(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h00);
    // Writing one to the flag must not set it
    host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h04);
    rd_chk(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h00);
    // A clear landing with a completed update loses to the set
    host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h03);
    fork
      host.wr(tlmm_pkg::ADDR_UPDATE_CONFIG, 8'h03);
      conv_chk(8'h20, 8'h20, exp_index(8'h20), 1'b1);
    join
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
